// >>> common/mvswp_pkg.sv
// Shared constants for the move/swap execution block and its register file.
// Assumes a 32-bit data path and one core clock.
package mvswp_pkg;
   // Data path and field widths
   localparam int DATA_W = 32;
   localparam int UREG_AW = 5;
   localparam int DREG_AW = 4;
   localparam int NUM_UREG = 32;
   localparam int NUM_DREG = 16;
   localparam int COND_W = 5;
   localparam int COMPUTE_W = 39;
   localparam int SHARED_BIT = 4;

   // Instruction field encodings
   localparam logic [COND_W-1:0] COND_ALWAYS = 5'h1F;
   localparam logic [COMPUTE_W-1:0] COMPUTE_NONE = 39'h00_0000_0000;

   // Instruction forms presented by the sequencer
   typedef enum logic [1:0] {
      FORM_LONG_MOVE = 2'b00,
      FORM_LONG_SWAP = 2'b01,
      FORM_SHORT_MOVE = 2'b10,
      FORM_SHORT_SWAP = 2'b11
   } form_e;

   // Register port offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_COUNT = 8'h08;
   localparam logic [7:0] OFF_LOAD_DATA = 8'h0C;
   localparam logic [7:0] OFF_LOAD_CMD = 8'h10;

   // Field positions
   localparam int CTRL_SIMD_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_X_EXEC_BIT = 1;
   localparam int STAT_Y_EXEC_BIT = 2;
   localparam int STAT_DROP_BIT = 3;
   localparam int STAT_LOAD_BIT = 4;
   localparam int LOAD_BANK_BIT = 8;
   localparam int LOAD_GO_BIT = 9;

   // Reset values
   localparam logic CTRL_SIMD_RST = 1'b0;
   localparam logic [DATA_W-1:0] COUNT_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] LOAD_DATA_RST = 32'h0000_0000;
endpackage : mvswp_pkg

// >>> common/regfile_if.sv
// Port bundle between the execution control and the two-bank register file.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
interface regfile_if;
   logic [mvswp_pkg::UREG_AW-1:0] rd_x_addr;
   logic [mvswp_pkg::DREG_AW-1:0] rd_y_addr;
   logic [mvswp_pkg::DATA_W-1:0] rd_x_data;
   logic [mvswp_pkg::DATA_W-1:0] rd_y_data;
   logic wr_x_en;
   logic [mvswp_pkg::UREG_AW-1:0] wr_x_addr;
   logic [mvswp_pkg::DATA_W-1:0] wr_x_data;
   logic wr_y_en;
   logic [mvswp_pkg::DREG_AW-1:0] wr_y_addr;
   logic [mvswp_pkg::DATA_W-1:0] wr_y_data;

   modport ctl (
      output rd_x_addr, rd_y_addr, wr_x_en, wr_x_addr, wr_x_data,
      output wr_y_en, wr_y_addr, wr_y_data,
      input rd_x_data, rd_y_data
   );
   modport mem (
      input rd_x_addr, rd_y_addr, wr_x_en, wr_x_addr, wr_x_data,
      input wr_y_en, wr_y_addr, wr_y_data,
      output rd_x_data, rd_y_data
   );
endinterface : regfile_if

// >>> core/uni_reg_mem.sv
// Two-bank register storage: the primary bank holds all universal registers,
// the secondary bank holds the complementary data registers only.
// Assumes the controller never reads and writes one entry in the same cycle.
`timescale 1ns/10ps
module uni_reg_mem (
   input wire logic i_clk_sys,
   regfile_if.mem rf
);
   logic [mvswp_pkg::DATA_W-1:0] x_bank [mvswp_pkg::NUM_UREG];
   logic [mvswp_pkg::DATA_W-1:0] y_bank [mvswp_pkg::NUM_DREG];
   logic [mvswp_pkg::DATA_W-1:0] rd_x_d;
   logic [mvswp_pkg::DATA_W-1:0] rd_y_d;
   logic [mvswp_pkg::DATA_W-1:0] rd_x_q;
   logic [mvswp_pkg::DATA_W-1:0] rd_y_q;

   // Read data are registered so the sources are sampled before any write lands
   always_comb begin
      rd_x_d = x_bank[rf.rd_x_addr];
      rd_y_d = y_bank[rf.rd_y_addr];
   end

   // Storage has no reset; software loads it before use
   always_ff @(posedge i_clk_sys) begin
      rd_x_q <= rd_x_d;
      rd_y_q <= rd_y_d;
      if (rf.wr_x_en) begin
         x_bank[rf.wr_x_addr] <= rf.wr_x_data;
      end
      if (rf.wr_y_en) begin
         y_bank[rf.wr_y_addr] <= rf.wr_y_data;
      end
   end

   assign rf.rd_x_data = rd_x_q;
   assign rf.rd_y_data = rd_y_q;
endmodule : uni_reg_mem

// >>> core/move_swap_exec.sv
// Decode and execution control for register move and swap instructions
// on a two-element core, with the register storage instantiated inside.
// Assumes the sequencer supplies each element's condition result on the
// core clock and holds an instruction until it is taken.
//
// Behaviour
// - Condition code 11111 is unconditional; any other code is conditional.
// - Long forms with an all-zero compute field carry no compute operation.
// - Single-element move copies source universal register into destination.
// - An encoded compute runs in the same instruction as the transfer.
// - A false condition suppresses both compute and register transfer.
// - Dual-element move runs in both elements, secondary on complementary registers.
// - Dual-element compute runs in both elements alongside the transfer.
// - In dual-element mode each element obeys only its own condition result, except for a shared destination.
// - Dual-element shared-destination transfer needs the condition true in both.
// - Swap exchanges a primary data register with a secondary data register.
// - Swap is identical in both modes; no extra secondary swap.
// - Short move and swap forms carry only a condition, never a compute.
`timescale 1ns/10ps
module move_swap_exec (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_instr_valid,
   input wire logic [1:0] i_instr_form,
   input wire logic [mvswp_pkg::COND_W-1:0] i_cond,
   input wire logic [mvswp_pkg::COMPUTE_W-1:0] i_compute,
   input wire logic [mvswp_pkg::UREG_AW-1:0] i_dst,
   input wire logic [mvswp_pkg::UREG_AW-1:0] i_src,
   input wire logic i_cond_x,
   input wire logic i_cond_y,
   output logic o_instr_ready,
   output logic o_compute_x,
   output logic o_compute_y,
   output logic [mvswp_pkg::COMPUTE_W-1:0] o_compute_op,
   output logic o_wr_x_en,
   output logic [mvswp_pkg::UREG_AW-1:0] o_wr_x_addr,
   output logic [mvswp_pkg::DATA_W-1:0] o_wr_x_data,
   output logic o_wr_y_en,
   output logic [mvswp_pkg::DREG_AW-1:0] o_wr_y_addr,
   output logic [mvswp_pkg::DATA_W-1:0] o_wr_y_data,
   output logic o_simd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [mvswp_pkg::DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [mvswp_pkg::DATA_W-1:0] o_reg_rdata
);
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_EXEC = 1'b1
   } exec_state_e;

   // Registers above the data-register range exist once and are shared
   function automatic logic is_shared(input logic [mvswp_pkg::UREG_AW-1:0] idx);
      is_shared = idx[mvswp_pkg::SHARED_BIT];
   endfunction : is_shared

   regfile_if rf ();

   uni_reg_mem u_mem (
      .i_clk_sys(i_clk_sys),
      .rf(rf)
   );

   // Instruction latch
   exec_state_e state_q, state_d;
   logic swap_q, swap_d;
   logic simd_q, simd_d;
   logic cx_q, cx_d;
   logic cy_q, cy_d;
   logic has_comp_q, has_comp_d;
   logic [mvswp_pkg::COMPUTE_W-1:0] comp_q, comp_d;
   logic [mvswp_pkg::UREG_AW-1:0] dst_q, dst_d;
   logic [mvswp_pkg::UREG_AW-1:0] src_q, src_d;
   logic accept;
   logic uncond;
   logic long_form;
   logic is_swap_in;

   // Software-visible state
   logic ctrl_simd_q, ctrl_simd_d;
   logic last_x_q, last_x_d;
   logic last_y_q, last_y_d;
   logic drop_q, drop_d;
   logic load_pend_q, load_pend_d;
   logic load_bank_q, load_bank_d;
   logic [mvswp_pkg::UREG_AW-1:0] load_addr_q, load_addr_d;
   logic [mvswp_pkg::DATA_W-1:0] load_data_q, load_data_d;
   logic [mvswp_pkg::DATA_W-1:0] count_q, count_d;
   logic [mvswp_pkg::DATA_W-1:0] rdata_q, rdata_d;
   logic load_set;

   // Write steering toward the storage
   logic exec;
   logic wx_en;
   logic [mvswp_pkg::UREG_AW-1:0] wx_addr;
   logic [mvswp_pkg::DATA_W-1:0] wx_data;
   logic wy_en;
   logic [mvswp_pkg::DREG_AW-1:0] wy_addr;
   logic [mvswp_pkg::DATA_W-1:0] wy_data;
   logic [mvswp_pkg::DATA_W-1:0] y_src;
   logic shared_drop;

   // Output registers
   logic cmp_x_d, cmp_y_d;
   logic [mvswp_pkg::COMPUTE_W-1:0] op_d;
   logic owx_en_d, owy_en_d;
   logic [mvswp_pkg::UREG_AW-1:0] owx_addr_d;
   logic [mvswp_pkg::DREG_AW-1:0] owy_addr_d;
   logic [mvswp_pkg::DATA_W-1:0] owx_data_d, owy_data_d;

   // Pending software loads hold off new instructions so the ports stay free
   assign o_instr_ready = (state_q == ST_IDLE) & ~load_pend_q;
   assign accept = i_instr_valid & o_instr_ready;
   assign exec = (state_q == ST_EXEC);
   assign o_simd = ctrl_simd_q;

   // Field decode of the incoming instruction
   always_comb begin
      uncond = (i_cond == mvswp_pkg::COND_ALWAYS);
      long_form = (i_instr_form == mvswp_pkg::FORM_LONG_MOVE) |
                  (i_instr_form == mvswp_pkg::FORM_LONG_SWAP);
      is_swap_in = (i_instr_form == mvswp_pkg::FORM_LONG_SWAP) |
                   (i_instr_form == mvswp_pkg::FORM_SHORT_SWAP);
   end

   // Sources are addressed at acceptance so read data arrive in the execute cycle
   always_comb begin
      rf.rd_x_addr = is_swap_in ? {1'b0, i_dst[mvswp_pkg::DREG_AW-1:0]} : i_src;
      rf.rd_y_addr = i_src[mvswp_pkg::DREG_AW-1:0];
   end

   // Sequencing: one accept cycle, one execute cycle
   always_comb begin
      state_d = state_q;
      swap_d = swap_q;
      simd_d = simd_q;
      cx_d = cx_q;
      cy_d = cy_q;
      has_comp_d = has_comp_q;
      comp_d = comp_q;
      dst_d = dst_q;
      src_d = src_q;
      unique case (state_q)
         ST_IDLE: begin
            if (accept) begin
               state_d = ST_EXEC;
               swap_d = is_swap_in;
               simd_d = ctrl_simd_q;
               cx_d = uncond | i_cond_x;
               cy_d = uncond | i_cond_y;
               has_comp_d = long_form & (i_compute != mvswp_pkg::COMPUTE_NONE);
               comp_d = i_compute;
               dst_d = i_dst;
               src_d = i_src;
            end
         end
         ST_EXEC: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= ST_IDLE;
         swap_q <= 1'b0;
         simd_q <= 1'b0;
         cx_q <= 1'b0;
         cy_q <= 1'b0;
         has_comp_q <= 1'b0;
         comp_q <= mvswp_pkg::COMPUTE_NONE;
         dst_q <= '0;
         src_q <= '0;
      end else begin
         state_q <= state_d;
         swap_q <= swap_d;
         simd_q <= simd_d;
         cx_q <= cx_d;
         cy_q <= cy_d;
         has_comp_q <= has_comp_d;
         comp_q <= comp_d;
         dst_q <= dst_d;
         src_q <= src_d;
      end
   end

   // A shared source has no secondary copy, so the secondary reads the primary bank
   assign y_src = is_shared(src_q) ? rf.rd_x_data : rf.rd_y_data;

   // Register transfer steering; loads use the same ports only while idle
   always_comb begin
      wx_en = 1'b0;
      wx_addr = dst_q;
      wx_data = rf.rd_x_data;
      wy_en = 1'b0;
      wy_addr = dst_q[mvswp_pkg::DREG_AW-1:0];
      wy_data = y_src;
      shared_drop = 1'b0;
      if (exec) begin
         if (swap_q) begin
            // Both values were read last cycle, so neither write can corrupt the other
            wx_en = cx_q;
            wx_addr = {1'b0, dst_q[mvswp_pkg::DREG_AW-1:0]};
            wx_data = rf.rd_y_data;
            wy_en = cx_q;
            wy_addr = src_q[mvswp_pkg::DREG_AW-1:0];
            wy_data = rf.rd_x_data;
         end else if (!simd_q) begin
            wx_en = cx_q;
         end else if (is_shared(dst_q)) begin
            wx_en = cx_q & cy_q;
            shared_drop = cx_q ^ cy_q;
         end else begin
            wx_en = cx_q;
            wy_en = cy_q;
         end
      end else if (load_pend_q) begin
         wx_en = ~load_bank_q;
         wx_addr = load_addr_q;
         wx_data = load_data_q;
         wy_en = load_bank_q;
         wy_addr = load_addr_q[mvswp_pkg::DREG_AW-1:0];
         wy_data = load_data_q;
      end
   end

   always_comb begin
      rf.wr_x_en = wx_en;
      rf.wr_x_addr = wx_addr;
      rf.wr_x_data = wx_data;
      rf.wr_y_en = wy_en;
      rf.wr_y_addr = wy_addr;
      rf.wr_y_data = wy_data;
   end

   // Compute issue and transfer report leave together, one cycle after execute
   always_comb begin
      cmp_x_d = exec & has_comp_q & cx_q;
      cmp_y_d = exec & has_comp_q & simd_q & cy_q;
      op_d = exec ? comp_q : o_compute_op;
      owx_en_d = exec & wx_en;
      owx_addr_d = wx_addr;
      owx_data_d = wx_data;
      owy_en_d = exec & wy_en;
      owy_addr_d = wy_addr;
      owy_data_d = wy_data;
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_compute_x <= 1'b0;
         o_compute_y <= 1'b0;
         o_compute_op <= mvswp_pkg::COMPUTE_NONE;
         o_wr_x_en <= 1'b0;
         o_wr_x_addr <= '0;
         o_wr_x_data <= '0;
         o_wr_y_en <= 1'b0;
         o_wr_y_addr <= '0;
         o_wr_y_data <= '0;
      end else begin
         o_compute_x <= cmp_x_d;
         o_compute_y <= cmp_y_d;
         o_compute_op <= op_d;
         o_wr_x_en <= owx_en_d;
         o_wr_x_addr <= owx_addr_d;
         o_wr_x_data <= owx_data_d;
         o_wr_y_en <= owy_en_d;
         o_wr_y_addr <= owy_addr_d;
         o_wr_y_data <= owy_data_d;
      end
   end

   // Register port: writes steer mode and loads, reads show execution state
   assign load_set = i_reg_wr & (i_reg_addr == mvswp_pkg::OFF_LOAD_CMD) &
                     i_reg_wdata[mvswp_pkg::LOAD_GO_BIT];

   always_comb begin
      ctrl_simd_d = ctrl_simd_q;
      load_data_d = load_data_q;
      load_addr_d = load_addr_q;
      load_bank_d = load_bank_q;
      load_pend_d = load_pend_q;
      last_x_d = last_x_q;
      last_y_d = last_y_q;
      drop_d = drop_q;
      count_d = count_q;
      rdata_d = '0;
      if (i_reg_wr && i_reg_addr == mvswp_pkg::OFF_CTRL) begin
         ctrl_simd_d = i_reg_wdata[mvswp_pkg::CTRL_SIMD_BIT];
      end
      if (i_reg_wr && i_reg_addr == mvswp_pkg::OFF_LOAD_DATA) begin
         load_data_d = i_reg_wdata;
      end
      // A load finishes in any idle cycle; a new request in that cycle still wins
      if (!exec && load_pend_q) begin
         load_pend_d = 1'b0;
      end
      if (load_set) begin
         load_pend_d = 1'b1;
         load_addr_d = i_reg_wdata[mvswp_pkg::UREG_AW-1:0];
         load_bank_d = i_reg_wdata[mvswp_pkg::LOAD_BANK_BIT];
      end
      if (exec) begin
         last_x_d = cx_q;
         last_y_d = simd_q & cy_q & ~swap_q;
         drop_d = shared_drop;
         count_d = count_q + 32'h0000_0001;
      end
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            mvswp_pkg::OFF_CTRL: rdata_d[mvswp_pkg::CTRL_SIMD_BIT] = ctrl_simd_q;
            mvswp_pkg::OFF_STATUS: begin
               rdata_d[mvswp_pkg::STAT_BUSY_BIT] = exec;
               rdata_d[mvswp_pkg::STAT_X_EXEC_BIT] = last_x_q;
               rdata_d[mvswp_pkg::STAT_Y_EXEC_BIT] = last_y_q;
               rdata_d[mvswp_pkg::STAT_DROP_BIT] = drop_q;
               rdata_d[mvswp_pkg::STAT_LOAD_BIT] = load_pend_q;
            end
            mvswp_pkg::OFF_COUNT: rdata_d = count_q;
            mvswp_pkg::OFF_LOAD_DATA: rdata_d = load_data_q;
            default: rdata_d = '0; // Unmapped offsets read zero
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_simd_q <= mvswp_pkg::CTRL_SIMD_RST;
         load_data_q <= mvswp_pkg::LOAD_DATA_RST;
         load_addr_q <= '0;
         load_bank_q <= 1'b0;
         load_pend_q <= 1'b0;
         last_x_q <= 1'b0;
         last_y_q <= 1'b0;
         drop_q <= 1'b0;
         count_q <= mvswp_pkg::COUNT_RST;
         rdata_q <= '0;
      end else begin
         ctrl_simd_q <= ctrl_simd_d;
         load_data_q <= load_data_d;
         load_addr_q <= load_addr_d;
         load_bank_q <= load_bank_d;
         load_pend_q <= load_pend_d;
         last_x_q <= last_x_d;
         last_y_q <= last_y_d;
         drop_q <= drop_d;
         count_q <= count_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_reg_rdata = rdata_q;
endmodule : move_swap_exec

// >>> tb/move_swap_exec_monitor.sv
// Concurrent checks on the move/swap block, seen from its top ports only.
// Assumes outputs answer two edges after the accepting edge.
`timescale 1ns/10ps
module move_swap_exec_monitor (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_instr_valid,
   input wire logic [1:0] i_instr_form,
   input wire logic [mvswp_pkg::COND_W-1:0] i_cond,
   input wire logic [mvswp_pkg::COMPUTE_W-1:0] i_compute,
   input wire logic [mvswp_pkg::UREG_AW-1:0] i_dst,
   input wire logic [mvswp_pkg::UREG_AW-1:0] i_src,
   input wire logic i_cond_x,
   input wire logic i_cond_y,
   input wire logic o_instr_ready,
   input wire logic o_compute_x,
   input wire logic o_compute_y,
   input wire logic o_wr_x_en,
   input wire logic [mvswp_pkg::UREG_AW-1:0] o_wr_x_addr,
   input wire logic o_wr_y_en,
   input wire logic [mvswp_pkg::DREG_AW-1:0] o_wr_y_addr,
   input wire logic o_simd
);
   logic acc, cx, cy, comp, mv;
   logic [3:0] src_lo;
   // Decoded view of the instruction on its accepting edge
   assign acc = i_instr_valid && o_instr_ready;
   assign cx = (i_cond == mvswp_pkg::COND_ALWAYS) || i_cond_x;
   assign cy = (i_cond == mvswp_pkg::COND_ALWAYS) || i_cond_y;
   assign comp = !i_instr_form[1] && (i_compute != mvswp_pkg::COMPUTE_NONE);
   assign mv = !i_instr_form[0];
   assign src_lo = i_src[3:0];

   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   cond_gate_a: assert property (acc && !cx |-> ##2 !o_compute_x && !o_wr_x_en)
      else $error("primary element acted on a false condition");
   uncond_run_a: assert property (acc && i_cond == 5'h1F && comp |-> ##2 o_compute_x)
      else $error("unconditional compute not issued");
   no_comp_a: assert property (acc && i_compute == 39'h0 |-> ##2 !o_compute_x && !o_compute_y)
      else $error("compute issued with empty field");
   short_form_a: assert property (acc && i_instr_form[1] |-> ##2 !o_compute_x && !o_compute_y)
      else $error("compute issued on short form");
   dual_comp_a: assert property (acc && comp && o_simd && cy |-> ##2 o_compute_y)
      else $error("secondary compute missing");
   sisd_move_a: assert property (acc && !o_simd && mv && cx
         |-> ##2 o_wr_x_en && !o_wr_y_en && o_wr_x_addr == $past(i_dst, 2))
      else $error("single element move wrong");
   local_cond_a: assert property (acc && o_simd && mv && !i_dst[4] && cy && !cx
         |-> ##2 o_wr_y_en && !o_wr_x_en)
      else $error("element did not follow own condition");
   shared_dst_a: assert property (acc && o_simd && mv && i_dst[4] && cx != cy
         |-> ##2 !o_wr_x_en && !o_wr_y_en)
      else $error("shared write on split condition");
   swap_pair_a: assert property (acc && !mv && cx
         |-> ##2 o_wr_x_en && o_wr_y_en && o_wr_y_addr == $past(src_lo, 2))
      else $error("swap did not write both elements");
   swap_local_a: assert property (acc && !mv && !cx |-> ##2 !o_wr_y_en)
      else $error("implied secondary swap seen");
endmodule : move_swap_exec_monitor

bind move_swap_exec move_swap_exec_monitor u_mon (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
   .i_instr_valid(i_instr_valid), .i_instr_form(i_instr_form), .i_cond(i_cond),
   .i_compute(i_compute), .i_dst(i_dst), .i_src(i_src), .i_cond_x(i_cond_x),
   .i_cond_y(i_cond_y), .o_instr_ready(o_instr_ready), .o_compute_x(o_compute_x),
   .o_compute_y(o_compute_y), .o_wr_x_en(o_wr_x_en), .o_wr_x_addr(o_wr_x_addr),
   .o_wr_y_en(o_wr_y_en), .o_wr_y_addr(o_wr_y_addr), .o_simd(o_simd));

// >>> tb/register_move_swap_exec_tb.sv
// Self-checking bench: loads registers, issues move and swap forms and
// judges write echoes and compute pulses. Assumes the package is compiled first.
`timescale 1ns/10ps
module register_move_swap_exec_tb;
   logic clk = 1'b0, rstn = 1'b0, vld = 1'b0, cx = 1'b0, cy = 1'b0, rw = 1'b0, rr = 1'b0;
   logic [1:0] form = 2'h0;
   logic [4:0] cnd = 5'h00, dst = 5'h00, src = 5'h00, wxa;
   logic [38:0] cmp = 39'h0, op;
   logic [7:0] ra = 8'h00;
   logic [31:0] wd = 32'h0, rd_v, wxd, wyd, rdat;
   logic [3:0] wya;
   logic rdy, ox, oy, wxe, wye, simd;
   int bad_count = 0, cmp_count = 0, n_ins = 0;

   // 10 MHz core clock
   always #50 clk = ~clk;

   move_swap_exec u_dut (.i_clk_sys(clk), .i_resetn(rstn), .i_instr_valid(vld),
      .i_instr_form(form), .i_cond(cnd), .i_compute(cmp), .i_dst(dst), .i_src(src),
      .i_cond_x(cx), .i_cond_y(cy), .o_instr_ready(rdy), .o_compute_x(ox),
      .o_compute_y(oy), .o_compute_op(op), .o_wr_x_en(wxe), .o_wr_x_addr(wxa),
      .o_wr_x_data(wxd), .o_wr_y_en(wye), .o_wr_y_addr(wya), .o_wr_y_data(wyd),
      .o_simd(simd), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(rw), .i_reg_rd(rr),
      .o_reg_rdata(rdat));

   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string n, input logic [38:0] e, input logic [38:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Register port cycles; read data is caught only in the cycle after the strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      rw <= 1'b1;
      @(posedge clk);
      rw <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      ra <= a;
      rr <= 1'b1;
      @(posedge clk);
      rr <= 1'b0;
      @(negedge clk);
      rd_v = rdat;
   endtask : rd

   // Bounded wait for the idle state, so a stuck load cannot hang the run
   task automatic idle();
      int i;
      i = 0;
      @(negedge clk);
      while (rdy !== 1'b1 && i < 50) begin
         @(negedge clk);
         i++;
      end
      chk("ready", 39'h1, {38'h0, rdy});
   endtask : idle

   task automatic load(input logic bank, input logic [4:0] a, input logic [31:0] d);
      wr(mvswp_pkg::OFF_LOAD_DATA, d);
      wr(mvswp_pkg::OFF_LOAD_CMD, {22'h0, 1'b1, bank, 3'h0, a});
      idle();
   endtask : load

   // Issue one instruction; ex = {compute x, compute y, write x, write y}
   task automatic run(input logic [1:0] f, input logic [4:0] c, input logic [38:0] k,
         input logic [4:0] d, input logic [4:0] s, input logic x, input logic y,
         input logic [3:0] ex, input logic [31:0] xd, input logic [31:0] yd);
      idle();
      @(posedge clk);
      form <= f;
      cnd <= c;
      cmp <= k;
      dst <= d;
      src <= s;
      cx <= x;
      cy <= y;
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      n_ins++;
      chk("pulses", ex, {ox, oy, wxe, wye});
      if (ex[3]) chk("compute op", k, op);
      if (ex[1]) chk("x addr", f[0] ? {1'b0, d[3:0]} : d, wxa);
      if (ex[1]) chk("x data", xd, wxd);
      if (ex[0]) chk("y addr", f[0] ? s[3:0] : d[3:0], wya);
      if (ex[0]) chk("y data", yd, wyd);
   endtask : run

   task automatic t_regs();
      rd(mvswp_pkg::OFF_CTRL);
      chk("ctrl reset", 39'h0, rd_v);
      rd(8'h40);
      chk("unmapped", 39'h0, rd_v);
      wr(mvswp_pkg::OFF_LOAD_DATA, 32'h5A5A_1234);
      rd(mvswp_pkg::OFF_LOAD_DATA);
      chk("load data", 39'h5A5A_1234, rd_v);
      wr(mvswp_pkg::OFF_COUNT, 32'hFFFF_FFFF);
      rd(mvswp_pkg::OFF_COUNT);
      chk("count ro", 39'h0, rd_v);
   endtask : t_regs

   task automatic t_sisd();
      load(1'b0, 5'h05, 32'h1111_0005);
      load(1'b0, 5'h03, 32'h3333_0003);
      run(2'h0, 5'h1F, 39'h0, 5'h03, 5'h05, 0, 0, 4'h2, 32'h1111_0005, 0);
      run(2'h0, 5'h04, 39'h12_3456_789A, 5'h03, 5'h05, 0, 1, 4'h0, 0, 0);
      run(2'h0, 5'h04, 39'h12_3456_789A, 5'h07, 5'h03, 1, 0, 4'hA, 32'h1111_0005, 0);
      run(2'h2, 5'h1F, 39'h7F_FFFF_FFFF, 5'h08, 5'h05, 0, 0, 4'h2, 32'h1111_0005, 0);
   endtask : t_sisd

   task automatic t_simd();
      wr(mvswp_pkg::OFF_CTRL, 32'h0000_0001);
      // Mode output updates on the strobe's own edge, so look at it mid-cycle
      @(negedge clk);
      chk("simd out", 39'h1, {38'h0, simd});
      load(1'b1, 5'h04, 32'h4444_000C);
      load(1'b0, 5'h04, 32'h4444_0004);
      run(2'h0, 5'h09, 39'h1, 5'h02, 5'h04, 0, 1, 4'h5, 0, 32'h4444_000C);
      run(2'h0, 5'h1F, 39'h0, 5'h02, 5'h04, 0, 0, 4'h3, 32'h4444_0004, 32'h4444_000C);
      run(2'h0, 5'h09, 39'h0, 5'h14, 5'h04, 1, 0, 4'h0, 0, 0);
      rd(mvswp_pkg::OFF_STATUS);
      chk("drop flag", 39'h1, {38'h0, rd_v[mvswp_pkg::STAT_DROP_BIT]});
      run(2'h0, 5'h09, 39'h0, 5'h14, 5'h04, 1, 1, 4'h2, 32'h4444_0004, 0);
   endtask : t_simd

   task automatic t_swap();
      load(1'b0, 5'h01, 32'hC0C0_0001);
      load(1'b1, 5'h06, 32'hD0D0_0006);
      run(2'h1, 5'h1F, 39'h0, 5'h01, 5'h06, 0, 0, 4'h3, 32'hD0D0_0006, 32'hC0C0_0001);
      run(2'h1, 5'h02, 39'h0, 5'h01, 5'h06, 0, 1, 4'h0, 0, 0);
      run(2'h3, 5'h02, 39'h3, 5'h01, 5'h06, 1, 0, 4'h3, 32'hC0C0_0001, 32'hD0D0_0006);
      wr(mvswp_pkg::OFF_CTRL, 32'h0000_0000);
      run(2'h1, 5'h1F, 39'h5, 5'h11, 5'h06, 0, 0, 4'hB, 32'hD0D0_0006, 32'hC0C0_0001);
   endtask : t_swap

   // Main sequence: reset, scenarios, instruction count, verdict
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_sisd();
      t_simd();
      t_swap();
      rd(mvswp_pkg::OFF_COUNT);
      chk("count", n_ins, rd_v);
      close_out();
   end

   // Watchdog well beyond the hundred or so cycles the scenarios need
   initial begin
      #(20000 * 100);
      bad_count++;
      close_out();
   end
endmodule : register_move_swap_exec_tb
